// ### hdl/rds_pkg.sv
// ==========================================================
// shared constants for the run/direction/speed select block
package rds_pkg;
  // ==========================================================
  // apb register byte offsets
  localparam logic [7:0] RDS_CTRL_OFS = 8'h00;
  localparam logic [7:0] RDS_TERM_FN_LO_OFS = 8'h04;
  localparam logic [7:0] RDS_TERM_FN_HI_OFS = 8'h08;
  localparam logic [7:0] RDS_TERM_REF_OFS = 8'h0C;
  localparam logic [7:0] RDS_EDIT_OFS = 8'h10;
  localparam logic [7:0] RDS_STORE_OFS = 8'h14;
  localparam logic [7:0] RDS_STATUS_OFS = 8'h18;
  localparam logic [7:0] RDS_OUT_FREQ_OFS = 8'h1C;
  localparam logic [7:0] RDS_PRESET_BASE_OFS = 8'h40;
  localparam logic [7:0] RDS_PRESET_END_OFS = 8'h7C;
  // ==========================================================
  // control register fields
  localparam int RDS_CTRL_SRC_LSB = 0;
  localparam int RDS_CTRL_METHOD_BIT = 2;
  localparam int RDS_CTRL_KEYDIR_BIT = 3;
  localparam int RDS_CTRL_KEYRUN_BIT = 4;
  localparam int RDS_CTRL_NC_LSB = 8;
  localparam logic [1:0] RDS_SRC_TERMINAL = 2'h1;
  localparam logic [1:0] RDS_SRC_KEYPAD = 2'h0;
  localparam logic [31:0] RDS_CTRL_RESET = 32'h0000_0001;
  // ==========================================================
  // input function codes, one 4-bit code per terminal
  localparam logic [3:0] RDS_FN_NONE = 4'h0;
  localparam logic [3:0] RDS_FN_REV = 4'h1;
  localparam logic [3:0] RDS_FN_BIN0 = 4'h2;
  localparam logic [3:0] RDS_FN_BIN3 = 4'h5;
  localparam logic [3:0] RDS_FN_HOT1 = 4'h8;
  localparam logic [3:0] RDS_FN_HOT7 = 4'hE;
  localparam logic [31:0] RDS_TERM_FN_RESET = 32'h0000_0000;
  // ==========================================================
  // frequency words and preset bank
  localparam int RDS_FREQ_W = 16;
  localparam int RDS_NUM_PRESETS = 16;
  localparam int RDS_NUM_TERMS = 8;
  localparam int RDS_SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    RDS_DIR_STOP,
    RDS_DIR_FWD,
    RDS_DIR_REV
  } rds_dir_e;
endpackage

// ### hdl/rds_preset_mem.sv
`timescale 1ns/1ps
// ==========================================================
// preset frequency bank, registered read ports
module rds_preset_mem
  import rds_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16,
  parameter int AW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr_a,
  output logic [WIDTH-1:0] rd_data_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [WIDTH-1:0] rd_data_b
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // storage, written only on an explicit store strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // registered read data for both ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      rd_data_a <= mem_reg[rd_addr_a];
      rd_data_b <= mem_reg[rd_addr_b];
    end
  end
endmodule // rds_preset_mem

// ### hdl/rds_pin_sync.sv
`timescale 1ns/1ps
// ==========================================================
// three-stage synchroniser with agreement filter per terminal
module rds_pin_sync
  import rds_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] level_out
);
  logic [N-1:0] s1_reg;
  logic [N-1:0] s2_reg;
  logic [N-1:0] s3_reg;

  // shift chain; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // accept a new level once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_out[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // rds_pin_sync

// ### hdl/rds_run_speed_select.sv
`timescale 1ns/1ps
// Function
// - forward input high runs forward, else stop
// - reverse input high runs reverse, else stop
// - both run requests active gives stop
// - normally closed terminals are inverted
// - keypad direction only steers keypad run key
// - sixteen stored preset frequencies in bank
// - binary index bit0 to bit3 from selects
// - binary selects assignable to any of terminals 1 to 8, not the forward pin
// - unassigned select bits count as zero
// - all selects off follows terminal reference
// - with terminal source, any select on uses decoded preset
// - preset changes only on explicit store
// - stop mode edits go to selected preset
// - up to seven one-hot selects, eight speeds
// - all one-hot selects off gives speed 0
// - lowest numbered active one-hot input wins
module rds_run_speed_select
  import rds_pkg::*;
#(
  parameter int FREQ_W = RDS_FREQ_W,
  parameter int NUM_TERMS = RDS_NUM_TERMS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic forward_run_input,
  input wire logic [NUM_TERMS-1:0] term_in,
  output logic run_fwd,
  output logic run_rev,
  output logic [FREQ_W-1:0] output_frequency_monitor
);
  // ==========================================================
  // declarations
  logic [31:0] ctrl_reg;
  logic [31:0] term_fn_lo_reg;
  logic [31:0] term_fn_hi_reg;
  logic [FREQ_W-1:0] term_ref_reg;
  logic [FREQ_W-1:0] edit_reg;
  logic [NUM_TERMS:0] pin_raw;
  logic [NUM_TERMS:0] pin_lvl;
  logic [NUM_TERMS:0] act;
  logic fwd_req;
  logic rev_req;
  logic [3:0] bin_idx;
  logic bin_any;
  logic [7:1] hot;
  logic [3:0] hot_idx;
  logic [3:0] sel_idx;
  logic sel_any;
  logic src_term;
  rds_dir_e dir_reg;
  rds_dir_e dir_next;
  logic mem_wr;
  logic [3:0] mem_waddr;
  logic [FREQ_W-1:0] mem_wdata;
  logic [3:0] rd_idx;
  logic [FREQ_W-1:0] preset_q;
  logic [FREQ_W-1:0] rd_preset_q;
  logic [31:0] rd_word;
  logic rd_pend_reg;
  logic rd_late_reg;
  logic setup_rd;
  logic acc;
  logic wr_acc;
  logic store_hit;
  logic preset_hit;
  logic mapped;

  // function code of terminal t (0 = dedicated forward pin)
  function automatic logic [3:0] fn_of(input int t,
                                       input logic [31:0] lo,
                                       input logic [31:0] hi);
    logic [63:0] codes;
    logic [3:0] code;
    codes = {hi, lo};
    code = 4'h0;
    if (t >= 1 && t <= 16) begin
      code = codes[4 * (t - 1) +: 4];
    end
    return code;
  endfunction

  // ==========================================================
  // input conditioning
  assign pin_raw = {term_in, forward_run_input};

  rds_pin_sync #(
    .N(NUM_TERMS + 1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pin_raw),
    .level_out(pin_lvl)
  );

  // normally closed terminals count open as active
  assign act = pin_lvl ^ ctrl_reg[RDS_CTRL_NC_LSB +: NUM_TERMS + 1];

  // ==========================================================
  // route terminal levels to functions by code
  always_comb begin
    logic [3:0] c;
    c = 4'h0;
    rev_req = 1'b0;
    bin_idx = 4'h0;
    hot = 7'h00;
    for (int t = 1; t <= NUM_TERMS; t++) begin
      c = fn_of(t, term_fn_lo_reg, term_fn_hi_reg);
      if (c == RDS_FN_REV && act[t]) begin
        rev_req = 1'b1;
      end
      if (c >= RDS_FN_BIN0 && c <= RDS_FN_BIN3 && act[t]) begin
        bin_idx[2'(c - RDS_FN_BIN0)] = 1'b1;
      end
      if (c >= RDS_FN_HOT1 && c <= RDS_FN_HOT7 && act[t]) begin
        hot[3'(c - RDS_FN_HOT1 + 4'h1)] = 1'b1;
      end
    end
  end
  assign fwd_req = act[0];
  assign bin_any = |bin_idx;

  // lowest numbered one-hot input decides the speed
  always_comb begin
    hot_idx = 4'h0;
    for (int i = 7; i >= 1; i--) begin
      if (hot[i]) begin
        hot_idx = 4'(i);
      end
    end
  end

  // method setting chooses which selects count
  assign sel_idx = ctrl_reg[RDS_CTRL_METHOD_BIT] ? hot_idx : bin_idx;
  assign sel_any = ctrl_reg[RDS_CTRL_METHOD_BIT] ? (|hot) : bin_any;
  assign src_term = ctrl_reg[RDS_CTRL_SRC_LSB +: 2] == RDS_SRC_TERMINAL;

  // ==========================================================
  // run and direction decode
  always_comb begin
    dir_next = RDS_DIR_STOP;
    if (src_term) begin
      if (fwd_req && rev_req) begin
        dir_next = RDS_DIR_STOP;
      end else if (fwd_req) begin
        dir_next = RDS_DIR_FWD;
      end else if (rev_req) begin
        dir_next = RDS_DIR_REV;
      end
    end else if (ctrl_reg[RDS_CTRL_KEYRUN_BIT]) begin
      // keypad direction touches the key only
      dir_next = ctrl_reg[RDS_CTRL_KEYDIR_BIT] ? RDS_DIR_REV : RDS_DIR_FWD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= RDS_DIR_STOP;
    end else begin
      dir_reg <= dir_next;
    end
  end
  assign run_fwd = dir_reg == RDS_DIR_FWD;
  assign run_rev = dir_reg == RDS_DIR_REV;

  // ==========================================================
  // preset bank and frequency selection
  rds_preset_mem #(
    .DEPTH(RDS_NUM_PRESETS),
    .WIDTH(FREQ_W),
    .AW(4)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mem_wr),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr_a(sel_idx),
    .rd_data_a(preset_q),
    .rd_addr_b(rd_idx),
    .rd_data_b(rd_preset_q)
  );

  // commanded frequency: with terminal source, preset overrides terminal reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_frequency_monitor <= '0;
    end else if (src_term && sel_any) begin
      output_frequency_monitor <= preset_q;
    end else begin
      output_frequency_monitor <= term_ref_reg;
    end
  end

  // ==========================================================
  // apb slave
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign preset_hit = paddr >= RDS_PRESET_BASE_OFS &&
                      paddr <= RDS_PRESET_END_OFS && paddr[1:0] == 2'h0;
  assign store_hit = paddr == RDS_STORE_OFS;
  assign rd_idx = paddr[5:2];
  assign mapped = preset_hit || paddr == RDS_CTRL_OFS ||
                  paddr == RDS_TERM_FN_LO_OFS || paddr == RDS_TERM_FN_HI_OFS ||
                  paddr == RDS_TERM_REF_OFS || paddr == RDS_EDIT_OFS ||
                  store_hit || paddr == RDS_STATUS_OFS ||
                  paddr == RDS_OUT_FREQ_OFS;
  // reads wait for the bank read and then the read data flop
  assign pready = pwrite || rd_late_reg;
  assign pslverr = acc && pready && !mapped;

  // store: direct slot write, or stop-mode teach of selected slot
  always_comb begin
    mem_wr = 1'b0;
    mem_waddr = rd_idx;
    mem_wdata = pwdata[FREQ_W-1:0];
    if (wr_acc && preset_hit) begin
      mem_wr = 1'b1;
    end else if (wr_acc && store_hit && dir_reg == RDS_DIR_STOP) begin
      mem_wr = 1'b1;
      mem_waddr = sel_idx;
      mem_wdata = edit_reg;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= RDS_CTRL_RESET;
      term_fn_lo_reg <= RDS_TERM_FN_RESET;
      term_fn_hi_reg <= RDS_TERM_FN_RESET;
      term_ref_reg <= '0;
      edit_reg <= '0;
    end else if (wr_acc) begin
      case (paddr)
        RDS_CTRL_OFS: ctrl_reg <= pwdata;
        RDS_TERM_FN_LO_OFS: term_fn_lo_reg <= pwdata;
        RDS_TERM_FN_HI_OFS: term_fn_hi_reg <= pwdata;
        RDS_TERM_REF_OFS: term_ref_reg <= pwdata[FREQ_W-1:0];
        RDS_EDIT_OFS: edit_reg <= pwdata[FREQ_W-1:0];
        default: ;
      endcase
    end
  end

  // read pending flags: bank read cycle, then data flop cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pend_reg <= 1'b0;
      rd_late_reg <= 1'b0;
    end else begin
      rd_pend_reg <= setup_rd;
      rd_late_reg <= rd_pend_reg;
    end
  end

  // read mux; status is {sel_any[16], sel_idx[15:12], levels[8:0]}
  always_comb begin
    rd_word = 32'h0000_0000;
    if (preset_hit) begin
      rd_word = 32'(rd_preset_q);
    end else begin
      case (paddr)
        RDS_CTRL_OFS: rd_word = ctrl_reg;
        RDS_TERM_FN_LO_OFS: rd_word = term_fn_lo_reg;
        RDS_TERM_FN_HI_OFS: rd_word = term_fn_hi_reg;
        RDS_TERM_REF_OFS: rd_word = 32'(term_ref_reg);
        RDS_EDIT_OFS: rd_word = 32'(edit_reg);
        RDS_STATUS_OFS: rd_word = {15'h0000, sel_any, sel_idx, 3'h0,
                                   pin_lvl};
        RDS_OUT_FREQ_OFS: rd_word = 32'(output_frequency_monitor);
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // read data flop, loaded once the bank word has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rd_pend_reg ? rd_word : 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  property p_both_stop;
    @(posedge pclk) disable iff (!presetn)
    (src_term && fwd_req && rev_req) |=> dir_reg == RDS_DIR_STOP;
  endproperty
  a_both_stop: assert property (p_both_stop) else $error("both run stop");

  property p_fwd;
    @(posedge pclk) disable iff (!presetn)
    (src_term && fwd_req && !rev_req) |=> run_fwd && !run_rev;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward not run");

  property p_rev;
    @(posedge pclk) disable iff (!presetn)
    (src_term && rev_req && !fwd_req) |=> run_rev && !run_fwd;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse not run");

  property p_ref;
    @(posedge pclk) disable iff (!presetn)
    (src_term && !sel_any) |=> output_frequency_monitor == $past(term_ref_reg);
  endproperty
  a_ref: assert property (p_ref) else $error("ref not followed");

  property p_preset;
    @(posedge pclk) disable iff (!presetn)
    (src_term && sel_any) |=> output_frequency_monitor == $past(preset_q);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not used");

  property p_hot0;
    @(posedge pclk) disable iff (!presetn)
    (hot == 7'h00) |-> hot_idx == 4'h0;
  endproperty
  a_hot0: assert property (p_hot0) else $error("onehot zero wrong");

  property p_hot_low;
    @(posedge pclk) disable iff (!presetn)
    hot[1] |-> hot_idx == 4'h1;
  endproperty
  a_hot_low: assert property (p_hot_low) else $error("lowest not won");

  property p_method;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_reg[RDS_CTRL_METHOD_BIT] |-> sel_idx == bin_idx;
  endproperty
  a_method: assert property (p_method) else $error("method wrong");

  property p_nostore;
    @(posedge pclk) disable iff (!presetn)
    !wr_acc |-> !mem_wr;
  endproperty
  a_nostore: assert property (p_nostore) else $error("store w/o write");

  c_fwd: cover property (@(posedge pclk) disable iff (!presetn) run_fwd);
  c_rev: cover property (@(posedge pclk) disable iff (!presetn) run_rev);
  c_teach: cover property (@(posedge pclk) disable iff (!presetn)
    wr_acc && store_hit && dir_reg == RDS_DIR_STOP);
endmodule // rds_run_speed_select

// ### sim/rds_switch_model.sv
`timescale 1ns/1ps
// ==========================================================
// switch bank or plc outputs wired to the drive terminals
module rds_switch_model (
  input wire logic pclk,
  input wire logic slow,
  input wire logic cmd_fwd,
  input wire logic [7:0] cmd_term,
  output logic forward_run_input,
  output logic [7:0] term_in
);
  logic [8:0] stage [0:3];
  // contacts start open
  initial begin
    foreach (stage[i]) stage[i] = 9'h000;
  end
  // contacts follow the command one cycle later, four when slow
  always @(posedge pclk) begin
    stage[0] <= {cmd_fwd, cmd_term};
    for (int i = 1; i < 4; i++) stage[i] <= stage[i-1];
  end
  assign {forward_run_input, term_in} = slow ? stage[3] : stage[0];
endmodule // rds_switch_model

// ### sim/tb_run_direction_speed_select.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the run/direction/speed select block
module tb_run_direction_speed_select import rds_pkg::*;;
  typedef struct packed {
    logic fwd;
    logic [7:0] term;
    logic efwd;
    logic erev;
    logic [4:0] eidx; // 5'h10 means terminal reference
  } rds_row_s;
  localparam logic [15:0] REF = 16'h0ABC;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic cmd_fwd = 1'b0;
  logic [7:0] cmd_term = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic forward_run_input;
  logic [7:0] term_in;
  logic run_fwd;
  logic run_rev;
  logic [15:0] out_freq;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int comparisons = 0;
  rds_row_s rows [10] = '{
    {1'b1, 8'h00, 1'b1, 1'b0, 5'h10}, {1'b0, 8'h01, 1'b0, 1'b1, 5'h10},
    {1'b1, 8'h01, 1'b0, 1'b0, 5'h10}, {1'b0, 8'h00, 1'b0, 1'b0, 5'h10},
    {1'b1, 8'h04, 1'b1, 1'b0, 5'h01}, {1'b1, 8'h10, 1'b1, 1'b0, 5'h02},
    {1'b1, 8'h08, 1'b1, 1'b0, 5'h04}, {1'b1, 8'h02, 1'b1, 1'b0, 5'h08},
    {1'b1, 8'h1E, 1'b1, 1'b0, 5'h0F}, {1'b1, 8'h0A, 1'b1, 1'b0, 5'h0C}};
  // ==========================================================
  // clock, design and switches
  always #2.5 pclk = ~pclk;
  rds_run_speed_select dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .forward_run_input(forward_run_input), .term_in(term_in),
    .run_fwd(run_fwd), .run_rev(run_rev),
    .output_frequency_monitor(out_freq));
  rds_switch_model sw_u (
    .pclk(pclk), .slow(slow), .cmd_fwd(cmd_fwd), .cmd_term(cmd_term),
    .forward_run_input(forward_run_input), .term_in(term_in));
  // ==========================================================
  // helpers
  function automatic logic [15:0] pv(input int i);
    return 16'h1000 + 16'(i) * 16'h0111;
  endfunction
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), w ? 32'h1 : 32'h2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(er, ee);
  endtask
  // set the switches, then let synchroniser and decode settle
  task automatic pins(input logic f, input logic [7:0] t);
    @(posedge pclk);
    cmd_fwd <= f;
    cmd_term <= t;
    repeat (14) @(posedge pclk);
  endtask
  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    chk({run_fwd, run_rev, out_freq}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(RDS_CTRL_OFS, RDS_CTRL_RESET, 1'b0);
    rdchk(RDS_TERM_FN_LO_OFS, RDS_TERM_FN_RESET, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr(RDS_PRESET_BASE_OFS + 8'(4 * i), {16'h0, pv(i)});
    end
    rdchk(RDS_PRESET_END_OFS, {16'h0, pv(15)}, 1'b0);
    rdchk(8'h20, 32'h0, 1'b1);
    wr(RDS_TERM_REF_OFS, {16'h0, REF});
    // binary selects on scrambled terminals, reverse on terminal 1
    wr(RDS_TERM_FN_LO_OFS, 32'h0003_4251);
    wr(RDS_TERM_FN_HI_OFS, 32'h0);
    foreach (rows[r]) begin
      pins(rows[r].fwd, rows[r].term);
      chk(run_fwd, rows[r].efwd);
      chk(run_rev, rows[r].erev);
      if (rows[r].efwd | rows[r].erev) begin
        chk(out_freq, rows[r].eidx[4] ? REF : pv(rows[r].eidx));
      end
    end
    // only the two low bits assigned, from the bottom up
    wr(RDS_TERM_FN_LO_OFS, 32'h0003_0201);
    pins(1'b1, 8'h1A);
    chk(out_freq, pv(2));
    pins(1'b1, 8'h00);
    chk(out_freq, REF);
    // normally closed forward pin, then reverse terminal
    wr(RDS_TERM_FN_LO_OFS, 32'h0003_4251);
    wr(RDS_CTRL_OFS, 32'h0000_0101);
    pins(1'b0, 8'h00);
    chk(run_fwd, 1'b1);
    wr(RDS_CTRL_OFS, 32'h0000_0201);
    pins(1'b0, 8'h00);
    chk({run_fwd, run_rev}, 2'b01);
    // keypad direction set to reverse leaves terminals alone
    wr(RDS_CTRL_OFS, 32'h0000_0009);
    pins(1'b1, 8'h00);
    chk({run_fwd, run_rev}, 2'b10);
    pins(1'b0, 8'h01);
    chk({run_fwd, run_rev}, 2'b01);
    // keypad source: run key with its direction, terminals ignored
    wr(RDS_CTRL_OFS, 32'h0000_0018);
    pins(1'b1, 8'h14);
    chk({run_fwd, run_rev}, 2'b01);
    chk(out_freq, REF);
    wr(RDS_CTRL_OFS, 32'h0000_0010);
    pins(1'b0, 8'h01);
    chk({run_fwd, run_rev}, 2'b10);
    // one-hot selects with a slow switch bank
    wr(RDS_CTRL_OFS, 32'h0000_0005);
    wr(RDS_TERM_FN_LO_OFS, 32'hEDCB_A981);
    slow <= 1'b1;
    for (int n = 1; n < 8; n++) begin
      pins(1'b1, 8'(1 << n) | 8'h80);
      apb(1'b0, RDS_STATUS_OFS, 32'h0);
      chk(rd[15:12], 4'(n));
      chk(out_freq, pv(n));
    end
    pins(1'b1, 8'h00);
    apb(1'b0, RDS_STATUS_OFS, 32'h0);
    chk(rd[15:12], 4'h0);
    slow <= 1'b0;
    // teach preset 3 from the selects while stopped
    wr(RDS_CTRL_OFS, 32'h0000_0001);
    wr(RDS_TERM_FN_LO_OFS, 32'h0003_4251);
    pins(1'b0, 8'h14);
    wr(RDS_EDIT_OFS, 32'h0000_5555);
    rdchk(RDS_PRESET_BASE_OFS + 8'h0C, {16'h0, pv(3)}, 1'b0);
    wr(RDS_STORE_OFS, 32'h1);
    rdchk(RDS_PRESET_BASE_OFS + 8'h0C, 32'h5555, 1'b0);
    pins(1'b1, 8'h14);
    chk(out_freq, 16'h5555);
    wr(RDS_EDIT_OFS, 32'h0000_6666);
    wr(RDS_STORE_OFS, 32'h1);
    rdchk(RDS_PRESET_BASE_OFS + 8'h0C, 32'h5555, 1'b0);
    // second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({run_fwd, run_rev, out_freq}, 32'h0);
    presetn <= 1'b1;
    rdchk(RDS_CTRL_OFS, RDS_CTRL_RESET, 1'b0);
    give_verdict();
  end
endmodule // tb_run_direction_speed_select
